// ### verilog/via_top.sv
`timescale 1ns/100ps
`include "via_cfg.svh"
// ==========================================================
// vectored interrupt arbiter
// ==========================================================
module via_top
#(
   parameter bit LARGE_VARIANT = 1'b1 // muldiv and timer1 present
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // request sources
   input wire logic low_voltage_event,
   input wire logic [5:0] ext_pin_in,
   input wire logic clocked_serial_done_irq,
   input wire logic async_tx_done_irq,
   input wire logic key_input_irq,
   input wire logic two_wire_done_irq,
   input wire logic muldiv_done_irq,
   input wire logic timer1_match_a_irq,
   input wire logic timer1_match_b_irq,
   input wire logic [12:0] plain_irq,
   // cpu core side
   input wire logic break_instruction,
   input wire logic cpu_ack,
   output logic int_req,
   output logic [15:0] entry_vector,
   output logic entry_valid,
   output via_pkg::via_entry_t entry_kind,
   output logic lvd_reset_req,
   output logic [15:0] reset_vector,
   output logic evt_irq
);
   localparam int NL = `VIA_NUM_LEVELS;

   // ==========================================================
   // storage
   // ==========================================================
   logic [31:0] req_q, req_d;   // request flags, four bytes
   logic [31:0] msk_q;          // mask flags
   logic [31:0] pri_q;          // priority select flags
   logic [5:0] rise_q;          // rising edge enables
   logic [5:0] fall_q;          // falling edge enables
   logic gie_q;                 // global enable
   logic insvc_q;               // in-service priority
   logic lvd_mode_q;            // low voltage mode select
   logic [2:0] evt_q, evt_d;    // sticky event status
   logic [2:0] evt_msk_q;       // event mask
   logic [7:0] rdata_q;         // registered read data
   logic [15:0] vec_q;          // last entry vector
   logic vld_q;                 // entry pulse
   via_pkg::via_entry_t kind_q; // kind of last entry
   logic lvr_q;                 // reset request pulse

   // ==========================================================
   // level to flag bit mapping
   // ==========================================================
   function automatic logic [4:0] flag_pos(input via_pkg::via_level_t l);
      begin
         if (l == 5'd22)
            flag_pos = `VIA_POS_L22;
         else if (l == 5'd23)
            flag_pos = `VIA_POS_L23;
         else if (l == 5'd24)
            flag_pos = `VIA_POS_L24;
         else
            flag_pos = l;
      end
   endfunction

   // vector table address for a level
   function automatic logic [15:0] level_vec(input via_pkg::via_level_t l);
      begin
         if (l == 5'd22)
            level_vec = `VIA_VEC_L22;
         else if (l == 5'd23)
            level_vec = `VIA_VEC_L23;
         else if (l == 5'd24)
            level_vec = `VIA_VEC_L24;
         else
            level_vec = `VIA_VEC_BASE + {10'h000, l, 1'b0};
      end
   endfunction

   // ==========================================================
   // pin edge detection
   // ==========================================================
   logic [5:0] pin_edge; // one pulse per detected edge

   // one detector per pin
   generate
      for (genvar g = 0; g < 6; g++)
      begin : g_pin
         via_pin_edge u_edge
         (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pin(ext_pin_in[g]),
            .rise_en(rise_q[g]),
            .fall_en(fall_q[g]),
            .edge_pulse(pin_edge[g])
         );
      end
   endgenerate

   // ==========================================================
   // request set vector
   // ==========================================================
   logic [31:0] req_set; // flags raised this cycle
   logic lvd_is_irq;     // low voltage routed as interrupt
   logic big;            // larger variant sources present

   // collect every source onto its flag bit
   always_comb
   begin
      big = LARGE_VARIANT;
      lvd_is_irq = ~lvd_mode_q;
      req_set = '0;
      req_set[0] = low_voltage_event & lvd_is_irq;
      req_set[6:1] = pin_edge;
      req_set[9:7] = plain_irq[2:0];
      // either serial source raises the shared flag
      req_set[10] = clocked_serial_done_irq | async_tx_done_irq;
      req_set[19:11] = plain_irq[11:3];
      req_set[20] = key_input_irq;
      req_set[21] = plain_irq[12];
      // muldiv shares the two-wire flag
      req_set[24] = two_wire_done_irq | (big & muldiv_done_irq);
      req_set[26] = big & timer1_match_a_irq;
      req_set[27] = big & timer1_match_b_irq;
   end

   // ==========================================================
   // arbitration
   // ==========================================================
   logic [NL-1:0] pend;   // unmasked pending per level
   logic [NL-1:0] grp_hi; // priority flag 0 group
   logic [NL-1:0] grp_lo; // priority flag 1 group
   logic fnd_hi, fnd_lo;  // group has a request
   via_pkg::via_level_t idx_hi, idx_lo; // group winners
   via_pkg::via_level_t win;  // overall winner
   logic win_pri;         // winner's priority flag
   logic [4:0] pos;       // scratch flag position

   // gather pending levels, masked ones drop out
   always_comb
   begin
      pend = '0;
      grp_hi = '0;
      grp_lo = '0;
      pos = '0;
      for (int i = 0; i < NL; i++)
      begin
         pos = flag_pos(via_pkg::via_level_t'(i));
         pend[i] = req_q[pos] & ~msk_q[pos];
         grp_hi[i] = pend[i] & ~pri_q[pos];
         grp_lo[i] = pend[i] & pri_q[pos];
      end
   end

   // default order inside the high group
   via_first_set #(.N(NL)) u_hi
   (
      .vec(grp_hi),
      .found(fnd_hi),
      .idx(idx_hi)
   );

   // default order inside the low group
   via_first_set #(.N(NL)) u_lo
   (
      .vec(grp_lo),
      .found(fnd_lo),
      .idx(idx_lo)
   );

   // high group beats low group, low blocked by in-service flag
   always_comb
   begin
      if (fnd_hi)
      begin
         win = idx_hi;
         win_pri = 1'b0;
      end
      else
      begin
         win = idx_lo;
         win_pri = 1'b1;
      end
      int_req = gie_q & (fnd_hi | (fnd_lo & insvc_q));
   end

   // ==========================================================
   // acknowledge and break
   // ==========================================================
   logic take_break; // break entry this cycle
   logic take_int; // maskable entry this cycle

   // break goes first and needs no enable
   always_comb
   begin
      take_break = break_instruction;
      take_int = cpu_ack & int_req & ~break_instruction;
   end

   // ==========================================================
   // register decode
   // ==========================================================
   logic wr_req, wr_msk, wr_pri; // byte group hit
   logic [1:0] lane;             // byte within group

   // decode which flag byte is written
   always_comb
   begin
      lane = reg_addr[1:0];
      wr_req = reg_wr & (reg_addr[7:2] == `VIA_OFS_REQ0L >> 2);
      wr_msk = reg_wr & (reg_addr[7:2] == `VIA_OFS_MSK0L >> 2);
      wr_pri = reg_wr & (reg_addr[7:2] == `VIA_OFS_PRI0L >> 2);
   end

   // next request flags: write, then ack clear, set wins
   always_comb
   begin
      req_d = req_q;
      if (wr_req)
         req_d[lane*8 +: 8] = reg_wdata;
      if (take_int)
         req_d[flag_pos(win)] = 1'b0;
      req_d = req_d | req_set;
   end

   // request flags, cleared by reset
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         req_q <= `VIA_REQ_RST;
      else
         req_q <= req_d;
   end

   // mask flags, all set after reset
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         msk_q <= `VIA_MSK_RST;
      else if (wr_msk)
         msk_q[lane*8 +: 8] <= reg_wdata;
   end

   // priority select flags
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         pri_q <= `VIA_MSK_RST;
      else if (wr_pri)
         pri_q[lane*8 +: 8] <= reg_wdata;
   end

   // edge enables and low voltage mode
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rise_q <= '0;
         fall_q <= '0;
         lvd_mode_q <= 1'b0;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `VIA_OFS_RISE)
            rise_q <= reg_wdata[5:0];
         if (reg_addr == `VIA_OFS_FALL)
            fall_q <= reg_wdata[5:0];
         if (reg_addr == `VIA_OFS_LVDC)
            lvd_mode_q <= reg_wdata[`VIA_LVD_MODE_BIT];
      end
   end

   // literal bits cannot be selected directly, so name the word
   localparam logic [7:0] STW_RST = `VIA_STW_RST; // status word reset

   // status word: entries clear enable, maskable entry loads in-service flag
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gie_q <= STW_RST[`VIA_STW_GIE_BIT];
         insvc_q <= STW_RST[`VIA_STW_INSVC_BIT];
      end
      else if (take_break)
         gie_q <= 1'b0;
      else if (take_int)
      begin
         gie_q <= 1'b0;
         insvc_q <= win_pri;
      end
      else if (reg_wr && reg_addr == `VIA_OFS_STWORD)
      begin
         gie_q <= reg_wdata[`VIA_STW_GIE_BIT];
         insvc_q <= reg_wdata[`VIA_STW_INSVC_BIT];
      end
   end

   // ==========================================================
   // entry outputs
   // ==========================================================
   // vector, kind and pulse one cycle after the entry
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vec_q <= `VIA_VEC_RESET;
         vld_q <= 1'b0;
         kind_q <= via_pkg::VIA_ENTRY_NONE;
      end
      else
      begin
         vld_q <= take_break | take_int;
         if (take_break)
         begin
            vec_q <= `VIA_VEC_BREAK;
            kind_q <= via_pkg::VIA_ENTRY_BREAK;
         end
         else if (take_int)
         begin
            vec_q <= level_vec(win);
            kind_q <= via_pkg::VIA_ENTRY_MASKABLE;
         end
      end
   end

   // low voltage as reset source, one cycle pulse
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         lvr_q <= 1'b0;
      else
         lvr_q <= low_voltage_event & lvd_mode_q;
   end

   // ==========================================================
   // event status, read clears, set wins
   // ==========================================================
   logic rd_evt; // status read this cycle

   // next sticky status
   always_comb
   begin
      rd_evt = reg_rd & (reg_addr == `VIA_OFS_EVT_STAT);
      evt_d = rd_evt ? 3'b000 : evt_q;
      evt_d[`VIA_EVT_ACK_BIT] = evt_d[`VIA_EVT_ACK_BIT] | take_int;
      evt_d[`VIA_EVT_BREAK_BIT] = evt_d[`VIA_EVT_BREAK_BIT] | take_break;
      evt_d[`VIA_EVT_LVR_BIT] = evt_d[`VIA_EVT_LVR_BIT] |
                                (low_voltage_event & lvd_mode_q);
   end

   // status and mask registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_q <= '0;
         evt_msk_q <= '0;
      end
      else
      begin
         evt_q <= evt_d;
         if (reg_wr && reg_addr == `VIA_OFS_EVT_MASK)
            evt_msk_q <= reg_wdata[2:0];
      end
   end

   // ==========================================================
   // read path
   // ==========================================================
   // read data registered, unmapped reads zero
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            8'h00, 8'h01, 8'h02, 8'h03:
               rdata_q <= req_q[lane*8 +: 8];
            8'h04, 8'h05, 8'h06, 8'h07:
               rdata_q <= msk_q[lane*8 +: 8];
            8'h08, 8'h09, 8'h0A, 8'h0B:
               rdata_q <= pri_q[lane*8 +: 8];
            `VIA_OFS_RISE:
               rdata_q <= {2'b00, rise_q};
            `VIA_OFS_FALL:
               rdata_q <= {2'b00, fall_q};
            `VIA_OFS_STWORD:
               rdata_q <= {gie_q, 5'b00000, insvc_q, 1'b0};
            `VIA_OFS_LVDC:
               rdata_q <= {6'b000000, lvd_mode_q, 1'b0};
            `VIA_OFS_EVT_STAT:
               rdata_q <= {5'b00000, evt_q};
            `VIA_OFS_EVT_MASK:
               rdata_q <= {5'b00000, evt_msk_q};
            `VIA_OFS_VEC_LO:
               rdata_q <= vec_q[7:0];
            `VIA_OFS_VEC_HI:
               rdata_q <= vec_q[15:8];
            default:
               rdata_q <= '0;
         endcase
      end
      else
         rdata_q <= '0;
   end

   // drive outputs
   always_comb
   begin
      reg_rdata = rdata_q;
      entry_vector = vec_q;
      entry_valid = vld_q;
      entry_kind = kind_q;
      lvd_reset_req = lvr_q;
      reset_vector = `VIA_VEC_RESET;
      evt_irq = |(evt_q & evt_msk_q);
   end
endmodule

// ### verilog/via_cfg.svh
// How it works
// - fixed default priority, level 0 highest, 24 lowest
// - two-wire and muldiv share level 22, 0034H
// - timer1 match a: level 23, vector 0038H
// - timer1 match b: level 24, vector 003AH
// - low voltage is interrupt while mode bit 0
// - mode bit 1: low voltage becomes reset source
// - clocked serial and async tx share flags
// - build parameter drops muldiv and timer1 sources
// - request, mask, priority flags per source, 4x8
// - pin edges per rising/falling enable registers
// - global enable and in-service priority gate acceptance
// - break instruction ignores enable and priority
// - acknowledge or reset clears request flag
// - reset loads the four interrupt mask registers with FFH, the event mask with 00H
`ifndef VIA_CFG_SVH
`define VIA_CFG_SVH

// ==========================================================
// register offsets
// ==========================================================
`define VIA_OFS_REQ0L 8'h00
`define VIA_OFS_MSK0L 8'h04
`define VIA_OFS_PRI0L 8'h08
`define VIA_OFS_RISE 8'h0C
`define VIA_OFS_FALL 8'h0D
`define VIA_OFS_STWORD 8'h0E
`define VIA_OFS_LVDC 8'h0F
`define VIA_OFS_EVT_STAT 8'h10
`define VIA_OFS_EVT_MASK 8'h11
`define VIA_OFS_VEC_LO 8'h12
`define VIA_OFS_VEC_HI 8'h13

// ==========================================================
// field positions and reset values
// ==========================================================
`define VIA_STW_GIE_BIT 7
`define VIA_STW_INSVC_BIT 1
`define VIA_STW_RST 8'h02
`define VIA_LVD_MODE_BIT 1
`define VIA_MSK_RST 32'hFFFF_FFFF
`define VIA_REQ_RST 32'h0000_0000
`define VIA_EVT_ACK_BIT 0
`define VIA_EVT_BREAK_BIT 1
`define VIA_EVT_LVR_BIT 2

// ==========================================================
// vector addresses and flag positions
// ==========================================================
`define VIA_VEC_BASE 16'h0004
`define VIA_VEC_L22 16'h0034
`define VIA_VEC_L23 16'h0038
`define VIA_VEC_L24 16'h003A
`define VIA_VEC_BREAK 16'h003E
`define VIA_VEC_RESET 16'h0000
`define VIA_POS_L22 5'd24
`define VIA_POS_L23 5'd26
`define VIA_POS_L24 5'd27
`define VIA_NUM_LEVELS 25

`endif

// ### verilog/via_pkg.sv
// ==========================================================
// shared types
// ==========================================================
package via_pkg;
   // which kind of entry the cpu was sent to
   typedef enum logic [1:0]
   {
      VIA_ENTRY_NONE = 2'b00,
      VIA_ENTRY_MASKABLE = 2'b01,
      VIA_ENTRY_BREAK = 2'b10
   } via_entry_t;
   // default priority level index
   typedef logic [4:0] via_level_t;
endpackage

// ### verilog/via_pin_edge.sv
`timescale 1ns/100ps
// ==========================================================
// edge detector for one external pin
// ==========================================================
module via_pin_edge
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic pin,      // pin level
   input wire logic rise_en,  // rising edge enable
   input wire logic fall_en,  // falling edge enable
   output logic edge_pulse    // one cycle on a chosen edge
);
   logic prev_q; // pin level last cycle

   // remember last level
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= 1'b0;
      else
         prev_q <= pin;
   end

   // pick edges by enables
   always_comb
   begin
      edge_pulse = (rise_en & pin & ~prev_q) |
                   (fall_en & ~pin & prev_q);
   end
endmodule

// ### verilog/via_first_set.sv
`timescale 1ns/100ps
// ==========================================================
// finds the lowest set bit, lowest index wins
// ==========================================================
module via_first_set
#(
   parameter int N = 25
)
(
   input wire logic [N-1:0] vec, // candidate requests
   output logic found,           // any bit set
   output via_pkg::via_level_t idx // lowest set index
);
   // scan from top down so the lowest index is kept
   always_comb
   begin
      found = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (vec[i])
         begin
            found = 1'b1;
            idx = via_pkg::via_level_t'(i);
         end
      end
   end
endmodule

// ### tb/via_top_properties.sv
`timescale 1ns/100ps
// ==========================================================
// port checker for the interrupt arbiter
// ==========================================================
module via_top_chk
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic low_voltage_event,
   input wire logic break_instruction,
   input wire logic cpu_ack,
   input wire logic int_req,
   input wire logic [15:0] entry_vector,
   input wire logic entry_valid,
   input wire via_pkg::via_entry_t entry_kind,
   input wire logic lvd_reset_req,
   input wire logic [15:0] reset_vector,
   input wire logic evt_irq
);
   // one domain: sys_clk, cleared by rst_n
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // cpu entries
   // ==========================================================
   maskable_take_a: assert property (
      cpu_ack && int_req && !break_instruction |=> entry_valid &&
      entry_kind == via_pkg::VIA_ENTRY_MASKABLE)
      else $error("maskable take did not enter");
   break_entry_a: assert property (
      break_instruction |=> entry_valid && entry_vector == 16'h003E &&
      entry_kind == via_pkg::VIA_ENTRY_BREAK)
      else $error("break entry missing or wrong vector");
   entry_cause_a: assert property (
      entry_valid |-> $past(break_instruction) ||
      ($past(cpu_ack) && $past(int_req)))
      else $error("entry without a take");
   entry_vec_a: assert property (
      entry_valid && entry_kind == via_pkg::VIA_ENTRY_MASKABLE |->
      !entry_vector[0] && entry_vector inside {[16'h0004:16'h002E],
      16'h0034, 16'h0038, 16'h003A})
      else $error("maskable vector outside the table");
   entry_blocks_a: assert property (
      entry_valid |-> !int_req)
      else $error("request still offered after entry");
   // ==========================================================
   // register port, reset side
   // ==========================================================
   rdata_idle_a: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside the answer cycle");
   lvd_reset_a: assert property (
      lvd_reset_req |-> $past(low_voltage_event))
      else $error("reset request without a low voltage event");
   reset_vec_a: assert property (
      reset_vector == 16'h0000)
      else $error("reset vector not zero");
   reset_quiet_a: assert property (
      !$past(rst_n) |-> !int_req && !entry_valid && !evt_irq)
      else $error("outputs active just after reset");
   // main scenarios reached
   cover property (entry_valid && entry_kind == via_pkg::VIA_ENTRY_MASKABLE);
   cover property (entry_valid && entry_kind == via_pkg::VIA_ENTRY_BREAK);
   cover property (lvd_reset_req);
endmodule

bind via_top via_top_chk chk (.*);

// ### tb/via_cpu_model.sv
`timescale 1ns/100ps
// ==========================================================
// cpu core model: takes a standing request after a delay
// ==========================================================
module via_cpu_model
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic int_req,         // request from the arbiter
   input wire logic ack_en,          // core willing to take
   input wire logic [3:0] ack_delay, // cycles to wait first
   output logic cpu_ack              // one-cycle take pulse
);
   logic [3:0] wait_q; // cycles the request has stood
   // ==========================================================
   // take pulse once the request has stood long enough
   // ==========================================================
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_q <= 4'h0;
         cpu_ack <= 1'b0;
      end
      else if (!int_req || cpu_ack)
      begin
         // gone or just taken: never ack twice in a row
         wait_q <= 4'h0;
         cpu_ack <= 1'b0;
      end
      else
      begin
         wait_q <= wait_q + 4'h1;
         cpu_ack <= ack_en && (wait_q >= ack_delay);
      end
   end
endmodule

// ### tb/via_top_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) \
   begin \
      cmp_count++; \
      if ((a) !== (e)) \
      begin \
         n_fail++; \
         $display("[FAIL] %0t got %h exp %h", $time, a, e); \
      end \
   end
// ==========================================================
// testbench for the vectored interrupt arbiter
// ==========================================================
module via_top_tb;
   logic sys_clk, rst_n, reg_wr, reg_rd, ack_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd2;
   logic [5:0] ext_pin_in;
   logic [12:0] plain_irq;
   logic [8:0] src; // packed one-cycle source pulses
   logic [3:0] ack_delay;
   logic cpu_ack, int_req, entry_valid, lvd_reset_req, evt_irq;
   logic [15:0] entry_vector, reset_vector;
   via_pkg::via_entry_t entry_kind;
   int n_fail, cmp_count, i;
   wire break_instruction, timer1_match_b_irq, timer1_match_a_irq;
   wire muldiv_done_irq, two_wire_done_irq, key_input_irq;
   wire async_tx_done_irq, clocked_serial_done_irq, low_voltage_event;
   assign {break_instruction, timer1_match_b_irq, timer1_match_a_irq,
      muldiv_done_irq, two_wire_done_irq, key_input_irq,
      async_tx_done_irq, clocked_serial_done_irq, low_voltage_event} = src;
   // full device and a small variant on the same inputs
   via_top dut (.*);
   via_top #(.LARGE_VARIANT(1'b0)) dut2 (.*, .reg_rdata(rd2), .int_req(),
      .entry_vector(), .entry_valid(), .entry_kind(), .lvd_reset_req(),
      .reset_vector(), .evt_irq());
   via_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .int_req(int_req),
      .ack_en(ack_en), .ack_delay(ack_delay), .cpu_ack(cpu_ack));
   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;
   // ==========================================================
   // bus and event tasks
   // ==========================================================
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   // one-cycle pulses on sources and plain lines
   task automatic fire(input logic [8:0] m, input logic [12:0] p);
      @(posedge sys_clk);
      src <= m;
      plain_irq <= p;
      @(posedge sys_clk);
      src <= 9'h000;
      plain_irq <= 13'h0000;
      #1;
   endtask
   // wait for the next entry, check it, then rewrite the status word
   task automatic take(input logic [15:0] v, input logic [7:0] stw);
      int k;
      via_pkg::via_entry_t kd; // kind the vector implies
      kd = (v == 16'h003E) ? via_pkg::VIA_ENTRY_BREAK :
         via_pkg::VIA_ENTRY_MASKABLE;
      for (k = 0; k < 20 && entry_valid !== 1'b1; k++)
      begin
         @(posedge sys_clk);
         #1;
      end
      `CHK(entry_valid, 1'b1)
      `CHK(entry_vector, v)
      `CHK(entry_kind, kd)
      wr(8'h0E, stw);
   endtask
   task automatic results();
      if (n_fail == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   // ==========================================================
   initial
   begin
      {sys_clk, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {ext_pin_in, plain_irq, src, n_fail, cmp_count} = '0;
      ack_en = 1'b1;
      ack_delay = 4'h0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         rd(8'h00 + i[7:0], 8'h00);
         rd(8'h04 + i[7:0], 8'hFF);
         wr(8'h04 + i[7:0], 8'h00);
         wr(8'h08 + i[7:0], 8'h00);
      end
      rd(8'h04, 8'h00);
      rd(8'h0E, 8'h02);
      rd(8'h20, 8'h00);
      // simultaneous requests while disabled, then break
      fire(9'h0F0, 13'h1000);
      `CHK(int_req, 1'b0)
      rd(8'h03, 8'h0D);
      `CHK(rd2, 8'h01)
      fire(9'h100, 13'h0000);
      take(16'h003E, 8'h82);
      take(16'h002E, 8'h82);
      take(16'h0034, 8'h82);
      take(16'h0038, 8'h82);
      take(16'h003A, 8'h02);
      rd(8'h03, 8'h00);
      // pins in low group, key masked, slow core
      ack_delay <= 4'h3;
      wr(8'h06, 8'h10);
      wr(8'h08, 8'h06);
      wr(8'h0C, 8'h01);
      wr(8'h0D, 8'h02);
      ext_pin_in <= 6'h03;
      repeat (3) @(posedge sys_clk);
      rd(8'h00, 8'h02);
      ext_pin_in <= 6'h01;
      repeat (3) @(posedge sys_clk);
      rd(8'h00, 8'h06);
      fire(9'h008, 13'h0000);
      wr(8'h0E, 8'h80);
      repeat (8) @(posedge sys_clk);
      #1;
      `CHK(int_req, 1'b0)
      wr(8'h06, 8'h00);
      take(16'h002C, 8'h82);
      take(16'h0006, 8'h82);
      take(16'h0008, 8'h02);
      // shared serial flag from either source
      fire(9'h002, 13'h0000);
      rd(8'h01, 8'h04);
      wr(8'h01, 8'h00);
      fire(9'h004, 13'h0000);
      rd(8'h01, 8'h04);
      wr(8'h0E, 8'h82);
      take(16'h0018, 8'h02);
      // low voltage: interrupt, then reset source
      fire(9'h001, 13'h0000);
      rd(8'h00, 8'h01);
      wr(8'h00, 8'h00);
      wr(8'h0F, 8'h02);
      fire(9'h001, 13'h0000);
      `CHK(lvd_reset_req, 1'b1)
      `CHK(reset_vector, 16'h0000)
      rd(8'h00, 8'h00);
      // event summary line and last vector
      #1;
      `CHK(evt_irq, 1'b0)
      wr(8'h11, 8'h04);
      #1;
      `CHK(evt_irq, 1'b1)
      rd(8'h10, 8'h07);
      `CHK(evt_irq, 1'b0)
      rd(8'h12, 8'h18);
      rd(8'h13, 8'h00);
      // muldiv alone: large build flags it, small build drops it
      fire(9'h020, 13'h0000);
      rd(8'h03, 8'h01);
      `CHK(rd2, 8'h00)
      results();
   end
   // watchdog against a hung wait
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      results();
   end
endmodule
